// *** hw/fifo_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface fifo_link_if;
  logic fifoClockOut;
  logic rxDataAvailable_n;
  logic txSpaceAvailable_n;
  logic readStrobe_n;
  logic writeStrobe_n;
  logic busOutputEnable_n;
  logic sendNowWakeup_n;
  logic usbConfigured_n;
  logic [7:0] devData;
  logic devDataOe_n;
  logic [7:0] hostData;
  logic hostDataOe_n;
  // resolved bus level: whoever enables drives, else pulled high
  logic [7:0] fifoDataBus;
  assign fifoDataBus = !devDataOe_n ? devData :
                       !hostDataOe_n ? hostData : 8'hff;
  modport device (
    output fifoClockOut, rxDataAvailable_n, txSpaceAvailable_n,
    output usbConfigured_n, devData, devDataOe_n,
    input readStrobe_n, writeStrobe_n, busOutputEnable_n,
    input sendNowWakeup_n, fifoDataBus
  );
  modport host (
    input fifoClockOut, rxDataAvailable_n, txSpaceAvailable_n,
    input usbConfigured_n, fifoDataBus,
    output readStrobe_n, writeStrobe_n, busOutputEnable_n,
    output sendNowWakeup_n, hostData, hostDataOe_n
  );
endinterface
`default_nettype wire

// *** hw/sync_fifo_device.sv ***
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - host enters mode after configuration and command
// - both sides move bytes on clock rise
// - device drives link clock; host synchronises
// - bus driven only while output enable low
// - read flag low while receive data present
// - one byte per clock with flag, strobe low
// - host lowers output enable before read strobe
// - present byte at strobe, advance every clock
// - write flag low while transmit space exists
// - capture byte when flag and strobe low
// - wake strobe in suspend requests USB resume
// - wake strobe otherwise flushes on next bulk IN
// - link clock stops during suspend
// - pull-down option blocks wake from suspend
module sync_fifo_device #(
  parameter int RX_DEPTH = sync_fifo_pkg::RX_DEPTH,
  parameter int TX_DEPTH = sync_fifo_pkg::TX_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // link
  fifo_link_if.device link,
  // usb side
  input wire logic modeActive,
  input wire logic usbSuspended,
  input wire logic remoteWakeEnable,
  input wire logic wakePullDownEnable,
  input wire logic rxInValid,
  input wire logic [7:0] rxInData,
  output logic rxInReady,
  output logic [7:0] txOutData,
  output logic txOutValid,
  input wire logic txOutReady,
  output logic resumeRequest,
  output logic flushRequest
);
  localparam int RXA = $clog2(RX_DEPTH);
  localparam int TXA = $clog2(TX_DEPTH);
  typedef struct packed {
    logic [3:0] divCnt;
    logic fifo_clock_out;
    logic [RX_DEPTH-1:0][7:0] rxMem;
    logic [RXA:0] rxWr;
    logic [RXA:0] rxRd;
    logic [TX_DEPTH-1:0][7:0] txMem;
    logic [TXA:0] txWr;
    logic [TXA:0] txRd;
    logic [7:0] busOut;
    logic rxFlag;
    logic txFlag;
    logic [2:0] oeSync;
    logic [2:0] rdSync;
    logic [2:0] wrSync;
    logic [2:0] wuSync;
    logic oeHeld;
    logic rdHeld;
    logic wrHeld;
    logic wuHeld;
    logic [23:0] busSync;
    logic wuPrev;
    logic resume;
    logic flush;
  } state_t;
  state_t state_reg, state_next;
  logic rise;
  logic rxEmpty, txFull, ready;
  logic oeN, rdN, wrN, wuN;
  logic [7:0] busIn;
  ///////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_next = state_reg;
    rxEmpty = state_reg.rxWr == state_reg.rxRd;
    txFull = (state_reg.txWr[TXA] != state_reg.txRd[TXA]) &&
             (state_reg.txWr[TXA-1:0] == state_reg.txRd[TXA-1:0]);
    ready = modeActive && !usbSuspended;
    // synchronise pins; second and third stages must agree
    state_next.oeSync = {state_reg.oeSync[1:0], link.busOutputEnable_n};
    state_next.rdSync = {state_reg.rdSync[1:0], link.readStrobe_n};
    state_next.wrSync = {state_reg.wrSync[1:0], link.writeStrobe_n};
    state_next.wuSync = {state_reg.wuSync[1:0], link.sendNowWakeup_n};
    state_next.busSync = {state_reg.busSync[15:0], link.fifoDataBus};
    // a stage pair that disagrees keeps the last settled level
    oeN = (state_reg.oeSync[2] == state_reg.oeSync[1]) ?
          state_reg.oeSync[2] : state_reg.oeHeld;
    rdN = (state_reg.rdSync[2] == state_reg.rdSync[1]) ?
          state_reg.rdSync[2] : state_reg.rdHeld;
    wrN = (state_reg.wrSync[2] == state_reg.wrSync[1]) ?
          state_reg.wrSync[2] : state_reg.wrHeld;
    wuN = (state_reg.wuSync[2] == state_reg.wuSync[1]) ?
          state_reg.wuSync[2] : state_reg.wuHeld;
    state_next.oeHeld = oeN;
    state_next.rdHeld = rdN;
    state_next.wrHeld = wrN;
    state_next.wuHeld = wuN;
    busIn = state_reg.busSync[23:16];
    // link clock divider, stopped while suspended
    rise = 1'b0;
    if (usbSuspended)
    begin
      state_next.divCnt = 4'h0;
      state_next.fifo_clock_out = 1'b0;
    end
    else if (state_reg.divCnt == sync_fifo_pkg::HALF_CNT)
    begin
      state_next.divCnt = 4'h0;
      state_next.fifo_clock_out = !state_reg.fifo_clock_out;
      rise = !state_reg.fifo_clock_out;
    end
    else
    begin
      state_next.divCnt = state_reg.divCnt + 4'h1;
    end
    // usb receive side fills the rx buffer
    rxInReady = ready && ((state_reg.rxWr[RXA] == state_reg.rxRd[RXA]) ||
                (state_reg.rxWr[RXA-1:0] != state_reg.rxRd[RXA-1:0]));
    if (rxInValid && rxInReady)
    begin
      state_next.rxMem[state_reg.rxWr[RXA-1:0]] = rxInData;
      state_next.rxWr = state_reg.rxWr + 1'b1;
    end
    txOutValid = state_reg.txWr != state_reg.txRd;
    txOutData = state_reg.txMem[state_reg.txRd[TXA-1:0]];
    if (txOutValid && txOutReady)
      state_next.txRd = state_reg.txRd + 1'b1;
    // all link transfers happen at the link clock rising edge
    if (rise)
    begin
      if (!state_reg.rxFlag && !rdN)
        state_next.rxRd = state_reg.rxRd + 1'b1;
      if (!state_reg.txFlag && !wrN)
      begin
        state_next.txMem[state_reg.txWr[TXA-1:0]] = busIn;
        state_next.txWr = state_reg.txWr + 1'b1;
      end
    end
    // flags and bus data follow the next-state pointers
    // flags move only at a link rise, or go high at once when not ready, so the host
    // sees each for a full period; a stale full flag between rises only costs throughput
    if (!ready)
    begin
      state_next.rxFlag = 1'b1;
      state_next.txFlag = 1'b1;
    end
    else if (rise)
    begin
      state_next.rxFlag = state_next.rxWr == state_next.rxRd;
      state_next.txFlag =
        (state_next.txWr[TXA] != state_next.txRd[TXA]) &&
        (state_next.txWr[TXA-1:0] == state_next.txRd[TXA-1:0]);
    end
    if (rise)
      state_next.busOut = state_next.rxMem[state_next.rxRd[RXA-1:0]];
    // wake strobe: falling edge on settled samples
    state_next.wuPrev = wuN;
    state_next.resume = 1'b0;
    state_next.flush = 1'b0;
    if (state_reg.wuPrev && !wuN)
    begin
      if (usbSuspended && remoteWakeEnable && !wakePullDownEnable)
        state_next.resume = 1'b1;
      else if (!usbSuspended)
        state_next.flush = 1'b1;
    end
  end
  ///////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
      state_reg.rxFlag <= 1'b1;
      state_reg.txFlag <= 1'b1;
      state_reg.oeSync <= 3'h7;
      state_reg.rdSync <= 3'h7;
      state_reg.wrSync <= 3'h7;
      state_reg.wuSync <= 3'h7;
      state_reg.wuPrev <= 1'b1;
      state_reg.oeHeld <= 1'b1;
      state_reg.rdHeld <= 1'b1;
      state_reg.wrHeld <= 1'b1;
      state_reg.wuHeld <= 1'b1;
    end
    else
      state_reg <= state_next;
  end
  ///////////////////////////////////////////////////////////////////////////
  assign link.fifoClockOut = state_reg.fifo_clock_out;
  assign link.rxDataAvailable_n = state_reg.rxFlag;
  assign link.txSpaceAvailable_n = state_reg.txFlag;
  assign link.usbConfigured_n = usbSuspended;
  assign link.devData = state_reg.busOut;
  // input unless host holds output enable low
  assign link.devDataOe_n = oeN;
  assign resumeRequest = state_reg.resume;
  assign flushRequest = state_reg.flush;
endmodule
`default_nettype wire

// *** hw/sync_fifo_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module sync_fifo_host (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // link
  fifo_link_if.host link,
  // user side
  input wire logic modeSelected,
  input wire logic readEnable,
  output logic [7:0] rdData,
  output logic rdValid,
  input wire logic [7:0] wrData,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic sendNow
);
  typedef struct packed {
    logic [2:0] clkSync;
    logic [2:0] rxfSync;
    logic [2:0] txeSync;
    logic [23:0] busSync;
    logic clkPrev;
    logic oe_n;
    logic rd_n;
    logic wr_n;
    logic wu_n;
    logic [7:0] wrHold;
    logic [7:0] rdByte;
    logic rdV;
  } state_t;
  state_t state_reg, state_next;
  logic rise;
  logic rxfN, txeN;
  ///////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_next = state_reg;
    state_next.clkSync = {state_reg.clkSync[1:0], link.fifoClockOut};
    state_next.rxfSync = {state_reg.rxfSync[1:0], link.rxDataAvailable_n};
    state_next.txeSync = {state_reg.txeSync[1:0], link.txSpaceAvailable_n};
    state_next.busSync = {state_reg.busSync[15:0], link.fifoDataBus};
    rxfN = state_reg.rxfSync[2];
    txeN = state_reg.txeSync[2];
    state_next.clkPrev = state_reg.clkSync[2];
    rise = state_reg.clkSync[2] && !state_reg.clkPrev;
    state_next.rdV = 1'b0;
    // reads win, so a write strobe never meets a bus turned toward us
    wrReady = rise && modeSelected && !txeN && state_reg.oe_n &&
              !(readEnable && !rxfN);
    // wake strobe must pass while the link clock is stopped
    state_next.wu_n = !sendNow;
    if (rise)
    begin
      // byte taken on this edge when flag and strobe both low
      if (!rxfN && !state_reg.rd_n)
      begin
        state_next.rdByte = state_reg.busSync[23:16];
        state_next.rdV = 1'b1;
      end
      // turnaround: output enable leads read strobe by a clock
      state_next.oe_n = !(modeSelected && readEnable && !rxfN);
      state_next.rd_n = state_reg.oe_n || !readEnable || rxfN;
      state_next.wr_n = !wrReady || !wrValid;
      if (wrReady && wrValid)
        state_next.wrHold = wrData;
    end
  end
  ///////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
      state_reg.rxfSync <= 3'h7;
      state_reg.txeSync <= 3'h7;
      state_reg.oe_n <= 1'b1;
      state_reg.rd_n <= 1'b1;
      state_reg.wr_n <= 1'b1;
      state_reg.wu_n <= 1'b1;
    end
    else
      state_reg <= state_next;
  end
  ///////////////////////////////////////////////////////////////////////////
  assign link.busOutputEnable_n = state_reg.oe_n;
  assign link.readStrobe_n = state_reg.rd_n;
  assign link.writeStrobe_n = state_reg.wr_n;
  assign link.sendNowWakeup_n = state_reg.wu_n;
  assign link.hostData = state_reg.wrHold;
  // host drives only while not asking the device to drive
  assign link.hostDataOe_n = state_reg.wr_n || !state_reg.oe_n;
  assign rdData = state_reg.rdByte;
  assign rdValid = state_reg.rdV;
endmodule
`default_nettype wire

// *** hw/sync_fifo_pkg.sv ***
package sync_fifo_pkg;
  localparam int DATA_W = 8;
  localparam int REF_CLK_MHZ = 200;
  localparam int LINK_CLK_MHZ = 60;
  // link clock half period in ref cycles; 200/60 is not whole, the divider
  // would alternate 2 and 1 cycles... kept simple: whole divide rounded up
  localparam int LINK_HALF_CYC = (REF_CLK_MHZ + 2 * LINK_CLK_MHZ - 1)
                                 / (2 * LINK_CLK_MHZ);
  localparam logic [3:0] HALF_CNT = 4'(LINK_HALF_CYC - 1);
  localparam int TURN_CLKS = 1;
  localparam int RX_DEPTH = 8;
  localparam int TX_DEPTH = 8;
  localparam logic [7:0] DATA_RST = 8'h00;
  typedef enum logic [1:0] {PORT_IDLE, PORT_READY} port_state_t;
endpackage

// *** verification/sync_fifo_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module sync_fifo_asserts (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // link
  input wire logic fifoClockOut,
  input wire logic rxDataAvailable_n,
  input wire logic txSpaceAvailable_n,
  input wire logic readStrobe_n,
  input wire logic writeStrobe_n,
  input wire logic busOutputEnable_n,
  input wire logic usbConfigured_n,
  input wire logic devDataOe_n,
  input wire logic hostDataOe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // divider halves are two ref cycles each
  sequence highTwo;
    fifoClockOut ##1 fifoClockOut ##1 !fifoClockOut;
  endsequence
  sequence longSuspend;
    usbConfigured_n [*6];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_clock_half: assert property ($rose(fifoClockOut) &&
    !usbConfigured_n |-> highTwo) else $error("link clock half wrong");
  a_clock_stops: assert property (longSuspend |->
    $stable(fifoClockOut)) else $error("link clock runs in suspend");
  a_flags_suspend: assert property (longSuspend |->
    rxDataAvailable_n && txSpaceAvailable_n) else $error("flags low");
  a_rx_flag_edge: assert property ($changed(rxDataAvailable_n) &&
    !usbConfigured_n |-> $rose(fifoClockOut)) else $error("rx flag off edge");
  a_tx_flag_edge: assert property ($changed(txSpaceAvailable_n) &&
    !usbConfigured_n |-> $rose(fifoClockOut)) else $error("tx flag off edge");
  a_no_clash: assert property (!devDataOe_n |-> hostDataOe_n)
    else $error("both ends drive the bus");
  a_drive_needs_oe: assert property ($fell(devDataOe_n) |->
    !busOutputEnable_n) else $error("device drives without enable");
  a_oe_before_rd: assert property ($fell(readStrobe_n) |->
    !$past(busOutputEnable_n, 3)) else $error("enable late for read");
  a_read_drives: assert property (!readStrobe_n |-> !devDataOe_n)
    else $error("read without device drive");
  a_write_drives: assert property (!writeStrobe_n |-> !hostDataOe_n)
    else $error("write without host drive");
endmodule
`default_nettype wire

// *** verification/sync_fifo_host_port_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module sync_fifo_host_port_bench;
  logic ref_clk, rst_n, modeActive, usbSuspended, remoteWakeEnable;
  logic wakePullDownEnable, rxInValid, rxInReady, txOutValid, txOutReady;
  logic resumeRequest, flushRequest, modeSelected, readEnable;
  logic rdValid, wrValid, wrReady, sendNow, hit;
  logic [7:0] rxInData, txOutData, rdData, wrData;
  logic [7:0] rdQ[$], txQ[$];
  logic [7:0] rows [6][2] = '{'{8'h00, 8'h00}, '{8'hff, 8'hff},
    '{8'ha5, 8'ha5}, '{8'h5a, 8'h5a}, '{8'h01, 8'h01}, '{8'h80, 8'h80}};
  int errTotal, samplesChecked;
  fifo_link_if link();
  wire [7:0] flagPair = {6'h00, link.rxDataAvailable_n, link.txSpaceAvailable_n};
  sync_fifo_device sync_fifo_device_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(link), .modeActive(modeActive), .usbSuspended(usbSuspended),
    .remoteWakeEnable(remoteWakeEnable), .wakePullDownEnable(wakePullDownEnable),
    .rxInValid(rxInValid), .rxInData(rxInData), .rxInReady(rxInReady),
    .txOutData(txOutData), .txOutValid(txOutValid), .txOutReady(txOutReady),
    .resumeRequest(resumeRequest), .flushRequest(flushRequest));
  sync_fifo_host sync_fifo_host_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(link), .modeSelected(modeSelected), .readEnable(readEnable),
    .rdData(rdData), .rdValid(rdValid), .wrData(wrData), .wrValid(wrValid),
    .wrReady(wrReady), .sendNow(sendNow));
  sync_fifo_asserts sync_fifo_asserts_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .fifoClockOut(link.fifoClockOut), .rxDataAvailable_n(link.rxDataAvailable_n),
    .txSpaceAvailable_n(link.txSpaceAvailable_n),
    .readStrobe_n(link.readStrobe_n), .writeStrobe_n(link.writeStrobe_n),
    .busOutputEnable_n(link.busOutputEnable_n),
    .usbConfigured_n(link.usbConfigured_n), .devDataOe_n(link.devDataOe_n),
    .hostDataOe_n(link.hostDataOe_n));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // pre-edge values: comb outputs are read before this edge updates them
  always @(posedge ref_clk)
  begin
    if (rdValid === 1'b1)
      rdQ.push_back(rdData);
    if (txOutValid === 1'b1 && txOutReady === 1'b1)
      txQ.push_back(txOutData);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic completeRun;
    $display("checked %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic hang;
    errTotal++;
    $display("BAD t=%0t wait timed out", $time);
    completeRun();
  endtask
  // valid stays up on return so a back-to-back push never drops it
  task automatic push(input logic wr, input logic [7:0] b);
    int n;
    if (wr)
      {wrValid, wrData} <= {1'b1, b};
    else
      {rxInValid, rxInData} <= {1'b1, b};
    for (n = 0; n < 400; n++)
    begin
      @(negedge ref_clk);
      if ((wr ? wrReady : rxInReady) === 1'b1)
        break;
    end
    if (n == 400)
      hang();
    @(posedge ref_clk);
  endtask
  task automatic waitQ(input int n);
    int k;
    for (k = 0; k < 3000 && (rdQ.size() < n || txQ.size() < n); k++)
      @(posedge ref_clk);
    if (k == 3000)
      hang();
  endtask
  task automatic watch(input logic f, output logic got);
    got = 1'b0;
    sendNow <= 1'b1;
    for (int k = 0; k < 200; k++)
    begin
      @(posedge ref_clk);
      if (k == 12)
        sendNow <= 1'b0;
      if ((f ? flushRequest : resumeRequest) === 1'b1)
        got = 1'b1;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {modeActive, usbSuspended, remoteWakeEnable, wakePullDownEnable} = 4'h0;
    {rxInValid, txOutReady, modeSelected, readEnable, wrValid, sendNow} = 6'h00;
    {rxInData, wrData, rst_n} = 17'h00000;
    repeat (5) @(posedge ref_clk);
    check(flagPair, 8'h03);
    check({7'h00, link.devDataOe_n}, 8'h01);
    rst_n <= 1'b1;
    repeat (30) @(posedge ref_clk);
    check(flagPair, 8'h03);
    {modeActive, modeSelected, readEnable, txOutReady} <= 4'hf;
    remoteWakeEnable <= 1'b1;
    $display("test reset done");
    foreach (rows[i])
    begin
      push(1'b0, rows[i][0]);
      rxInValid <= 1'b0;
      push(1'b1, rows[i][0]);
      wrValid <= 1'b0;
      waitQ(1);
      check(rdQ.pop_front(), rows[i][1]);
      check(txQ.pop_front(), rows[i][1]);
    end
    $display("test rows done");
    // both far sides stall so the bytes pile up and then leave in bursts
    {readEnable, txOutReady} <= 2'h0;
    for (int k = 0; k < 8; k++)
      push(1'b0, 8'h30 + k[7:0]);
    rxInValid <= 1'b0;
    for (int k = 0; k < 8; k++)
      push(1'b1, 8'hc0 + k[7:0]);
    {wrValid, readEnable, txOutReady} <= 3'h3;
    waitQ(8);
    for (int k = 0; k < 8; k++)
    begin
      check(rdQ.pop_front(), 8'h30 + k[7:0]);
      check(txQ.pop_front(), 8'hc0 + k[7:0]);
    end
    $display("test burst done");
    usbSuspended <= 1'b1;
    repeat (20) @(posedge ref_clk);
    check(flagPair, 8'h03);
    watch(1'b0, hit);
    check({7'h00, hit}, 8'h01);
    wakePullDownEnable <= 1'b1;
    watch(1'b0, hit);
    check({7'h00, hit}, 8'h00);
    {usbSuspended, wakePullDownEnable} <= 2'h0;
    repeat (20) @(posedge ref_clk);
    watch(1'b1, hit);
    check({7'h00, hit}, 8'h01);
    $display("test wake done");
    completeRun();
  end
endmodule
`default_nettype wire
